/* hw/plmc_cfg.svh */
// Constants of the PHY link and mode control register pair
// Function
// - Bits 9:8 pick seven, five, four, three attempts
// - Speed optimizer runs only while bit seven set
// - Bits 5:4 select idle error break threshold
// - Link break acts only when bit three set
// - Bit two low keeps automatic power optimization
// - Writing one to bit zero pulses logic reset
// - Logic reset bit keeps value until rewritten
// - Bit fifteen selects short energy detect mode
// - Bit fourteen enables ten meg fast test
// - Bit thirteen enables energy detect power down
// - Bit twelve sends link pulses during power-down
// - Bit six enables next pages, reset one
// - Bit five high selects manual crossover
// - Bit four defers next pages to advertisement
// - Energy bit: hardware reset one, software clears
// - Soft reset clearing set energy bit raises change flag
// - Bit zero enables semi crossover, reset zero
// - Manual select per pair: zero MDI, one MDI-X
`ifndef PLMC_CFG_SVH
`define PLMC_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define PLMC_LINK_CTL_ADDR    5'h10
`define PLMC_MODE_CTL_ADDR    5'h11
`define PLMC_LINK_CTL_RST     16'h0020
`define PLMC_MODE_CTL_RST     16'h0042

// ****************************************
// Link control fields
// ****************************************
`define PLMC_LC_SPD_HI        9
`define PLMC_LC_SPD_LO        8
`define PLMC_LC_LBT_HI        5
`define PLMC_LC_LBT_LO        4
`define PLMC_LC_LB_EN         3
`define PLMC_LC_PWR_DIS       2
`define PLMC_LC_LOGIC_RST     0

// ****************************************
// Mode control fields
// ****************************************
`define PLMC_MC_SHORT_ED      15
`define PLMC_MC_FAST          14
`define PLMC_MC_EDPD          13
`define PLMC_MC_NLP           12
`define PLMC_MC_SPD_EN        7
`define PLMC_MC_NP_EN         6
`define PLMC_MC_MDIX_DIS      5
`define PLMC_MC_ANP_DIS       4
`define PLMC_MC_ENERGY        1
`define PLMC_MC_SEMI          0

// ****************************************
// Management frame
// ****************************************
`define PLMC_PREAMBLE_LEN     6'h20
`define PLMC_HDR_BITS         6'h0D
`define PLMC_TA_BITS          6'h02
`define PLMC_DATA_BITS        6'h10
`define PLMC_OP_READ          2'h2
`define PLMC_OP_WRITE         2'h1
`define PLMC_THR_EXP_BASE     4'h8

`endif

/* hw/plmc_pkg.sv */
// Types of the PHY link and mode control register pair
`default_nettype none
package plmc_pkg;

  typedef enum logic [3:0] {
    PLMC_PRE  = 4'h1,
    PLMC_HDR  = 4'h2,
    PLMC_TA   = 4'h4,
    PLMC_DATA = 4'h8
  } plmc_fsm_t;

  typedef struct packed {
    logic       speed_opt_enable;
    logic [2:0] speed_opt_attempts;
    logic       link_break_enable;
    logic [1:0] link_break_thr_sel;
    logic [3:0] link_break_thr_exp;
    logic       power_opt_enable;
    logic       short_energy_detect_select;
    logic       ten_meg_test_mode;
    logic       energy_power_down_enable;
    logic       edpd_nlp_enable;
    logic       next_page_enable;
    logic       auto_mdix_enable;
    logic [1:0] mdix_pair_sel;
    logic       auto_np_disable;
    logic       np_advertise;
    logic       semi_crossover_enable;
    logic       line_energy_present;
  } plmc_cfg_t;

  typedef struct packed {
    logic [15:0] link_ctl;
    logic [15:0] mode_ctl;
    logic [2:0]  mdc_sync;
    logic [1:0]  mdio_sync;
    logic [4:0]  addr_s1;
    logic [4:0]  addr_s2;
    plmc_fsm_t   fsm;
    logic [5:0]  cnt;
    logic [12:0] hdr;
    logic [15:0] shreg;
    logic        hit;
    logic        mdio_out;
    logic        mdio_oe;
    logic        logic_reset_pulse;
    logic        energy_change_set;
    plmc_cfg_t   cfg;
  } plmc_state_t;

endpackage
`default_nettype wire

/* hw/plmc_regs.sv */
// Link control and 10/100 mode control registers behind the management interface
`include "plmc_cfg.svh"
`default_nettype none
module plmc_regs (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Management pins
  input  wire logic             mdc,
  input  wire logic             mdio_in,
  output logic                  mdio_out,
  output logic                  mdio_oe,
  input  wire logic [4:0]       phy_addr,
  // Core status and controls
  input  wire logic             soft_rst,
  input  wire logic             energy_detect,
  input  wire logic [1:0]       mdix_manual_sel,
  input  wire logic [1:0]       mdix_auto_sel,
  input  wire logic             adv_next_page,
  // Core configuration
  output plmc_pkg::plmc_cfg_t   cfg,
  output logic                  logic_reset_pulse,
  output logic                  energy_change_set
);
  import plmc_pkg::*;

  // ****************************************
  // Reset values
  // ****************************************
  localparam plmc_cfg_t CFG_RST = '{
    speed_opt_enable:           1'h0,
    speed_opt_attempts:         3'h7,
    link_break_enable:          1'h0,
    link_break_thr_sel:         2'h2,
    link_break_thr_exp:         4'hA,
    power_opt_enable:           1'h1,
    short_energy_detect_select: 1'h0,
    ten_meg_test_mode:          1'h0,
    energy_power_down_enable:   1'h0,
    edpd_nlp_enable:            1'h0,
    next_page_enable:           1'h1,
    auto_mdix_enable:           1'h1,
    mdix_pair_sel:              2'h0,
    auto_np_disable:            1'h0,
    np_advertise:               1'h1,
    semi_crossover_enable:      1'h0,
    line_energy_present:        1'h1
  };

  localparam plmc_state_t ST_RST = '{
    link_ctl:          `PLMC_LINK_CTL_RST,
    mode_ctl:          `PLMC_MODE_CTL_RST,
    mdc_sync:          3'h0,
    mdio_sync:         2'h3,
    addr_s1:           5'h00,
    addr_s2:           5'h00,
    fsm:               PLMC_PRE,
    cnt:               6'h00,
    hdr:               13'h0000,
    shreg:             16'h0000,
    hit:               1'h0,
    mdio_out:          1'h0,
    mdio_oe:           1'h0,
    logic_reset_pulse: 1'h0,
    energy_change_set: 1'h0,
    cfg:               CFG_RST
  };

  // ****************************************
  // Write masks
  // ****************************************
  // Bits outside the mask are reserved or read-only
  // Writable bits of each register; all others read zero or hardware state
  localparam logic [15:0] LC_WMASK = 16'h033D;
  localparam logic [15:0] MC_WMASK = 16'hF0F1;

  // ****************************************
  // State
  // ****************************************
  plmc_state_t st_r;
  plmc_state_t st_nxt;

  // ****************************************
  // Attempt count decode
  // ****************************************
  // Failed attempts before the advertised speed drops
  function automatic logic [2:0] plmc_attempts(input logic [1:0] sel);
    logic [2:0] n;
    n = 3'h7;
    case (sel)
      2'h0: n = 3'h7;
      2'h1: n = 3'h5;
      2'h2: n = 3'h4;
      default: n = 3'h3;
    endcase
    return n;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic        mdc_rise;
  logic        mdio_bit;
  logic [1:0]  hdr_op;
  logic [4:0]  hdr_phy;
  logic [4:0]  hdr_reg;
  logic        reg_lc;
  logic        reg_mc;
  logic [15:0] rd_data;
  logic [15:0] wr_data;
  logic        wr_commit;
  logic        addr_match;
  logic        frame_ok;

  always_comb begin
    st_nxt = st_r;
    st_nxt.logic_reset_pulse = 1'h0;
    st_nxt.energy_change_set = 1'h0;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Only the edge detector reads the third stage of the clock pin
    st_nxt.mdc_sync = {st_r.mdc_sync[1:0], mdc};
    st_nxt.mdio_sync = {st_r.mdio_sync[0], mdio_in};
    st_nxt.addr_s1 = phy_addr;
    st_nxt.addr_s2 = st_r.addr_s1;
    mdc_rise = st_r.mdc_sync[1] & ~st_r.mdc_sync[2];
    mdio_bit = st_r.mdio_sync[1];

    // ****************************************
    // Header fields and register decode
    // ****************************************
    hdr_op = st_r.hdr[11:10];
    hdr_phy = st_r.hdr[9:5];
    hdr_reg = st_r.hdr[4:0];
    reg_lc = 1'h0;
    reg_mc = 1'h0;
    if (hdr_reg == `PLMC_LINK_CTL_ADDR) begin
      reg_lc = 1'h1;
    end else if (hdr_reg == `PLMC_MODE_CTL_ADDR) begin
      reg_mc = 1'h1;
    end

    // ****************************************
    // Frame acceptance
    // ****************************************
    // Frame is ours when start bit and address both match
    addr_match = (hdr_phy == st_r.addr_s2);
    frame_ok = st_r.hdr[12] && addr_match;

    // ****************************************
    // Read data, field by field
    // ****************************************
    // Reserved positions stay zero
    rd_data = 16'h0000;
    if (reg_lc) begin
      rd_data[`PLMC_LC_SPD_HI:`PLMC_LC_SPD_LO] =
        st_r.link_ctl[`PLMC_LC_SPD_HI:`PLMC_LC_SPD_LO];
      rd_data[`PLMC_LC_LBT_HI:`PLMC_LC_LBT_LO] =
        st_r.link_ctl[`PLMC_LC_LBT_HI:`PLMC_LC_LBT_LO];
      rd_data[`PLMC_LC_LB_EN] = st_r.link_ctl[`PLMC_LC_LB_EN];
      rd_data[`PLMC_LC_PWR_DIS] = st_r.link_ctl[`PLMC_LC_PWR_DIS];
      rd_data[`PLMC_LC_LOGIC_RST] = st_r.link_ctl[`PLMC_LC_LOGIC_RST];
    end else if (reg_mc) begin
      rd_data[`PLMC_MC_SHORT_ED] = st_r.mode_ctl[`PLMC_MC_SHORT_ED];
      rd_data[`PLMC_MC_FAST] = st_r.mode_ctl[`PLMC_MC_FAST];
      rd_data[`PLMC_MC_EDPD] = st_r.mode_ctl[`PLMC_MC_EDPD];
      rd_data[`PLMC_MC_NLP] = st_r.mode_ctl[`PLMC_MC_NLP];
      rd_data[`PLMC_MC_SPD_EN] = st_r.mode_ctl[`PLMC_MC_SPD_EN];
      rd_data[`PLMC_MC_NP_EN] = st_r.mode_ctl[`PLMC_MC_NP_EN];
      rd_data[`PLMC_MC_MDIX_DIS] = st_r.mode_ctl[`PLMC_MC_MDIX_DIS];
      rd_data[`PLMC_MC_ANP_DIS] = st_r.mode_ctl[`PLMC_MC_ANP_DIS];
      rd_data[`PLMC_MC_ENERGY] = st_r.cfg.line_energy_present;
      rd_data[`PLMC_MC_SEMI] = st_r.mode_ctl[`PLMC_MC_SEMI];
    end

    // ****************************************
    // Write data
    // ****************************************
    wr_data = {st_r.shreg[14:0], mdio_bit};
    wr_commit = 1'h0;

    // ****************************************
    // Management frame engine
    // ****************************************
    if (mdc_rise) begin
      case (st_r.fsm)
        PLMC_PRE: begin
          // Count ones to a full preamble; a zero after it starts the header
          if (mdio_bit) begin
            if (st_r.cnt != `PLMC_PREAMBLE_LEN) begin
              st_nxt.cnt = st_r.cnt + 6'h01;
            end
          end else if (st_r.cnt == `PLMC_PREAMBLE_LEN) begin
            st_nxt.fsm = PLMC_HDR;
            st_nxt.cnt = 6'h00;
          end else begin
            st_nxt.cnt = 6'h00;
          end
        end
        PLMC_HDR: begin
          // Start bit, opcode, address and register, MSB first
          st_nxt.hdr = {st_r.hdr[11:0], mdio_bit};
          st_nxt.cnt = st_r.cnt + 6'h01;
          if (st_r.cnt == `PLMC_HDR_BITS - 6'h01) begin
            st_nxt.fsm = PLMC_TA;
            st_nxt.cnt = 6'h00;
          end
        end
        PLMC_TA: begin
          st_nxt.cnt = st_r.cnt + 6'h01;
          if (st_r.cnt == 6'h00) begin
            // Turnaround of a read to our address: device takes the pin and drives zero
            st_nxt.hit = frame_ok && (reg_lc || reg_mc);
            if (frame_ok && (hdr_op == `PLMC_OP_READ)) begin
              st_nxt.mdio_oe = 1'h1;
              st_nxt.mdio_out = 1'h0;
              st_nxt.shreg = rd_data;
            end
          end else begin
            // Second turnaround bit puts the MSB on the pin
            st_nxt.fsm = PLMC_DATA;
            st_nxt.cnt = 6'h00;
            st_nxt.mdio_out = st_r.shreg[15];
            st_nxt.shreg = {st_r.shreg[14:0], 1'h0};
            if (hdr_op == `PLMC_OP_WRITE) begin
              st_nxt.shreg = 16'h0000;
            end
          end
        end
        PLMC_DATA: begin
          st_nxt.cnt = st_r.cnt + 6'h01;
          if (hdr_op == `PLMC_OP_WRITE) begin
            st_nxt.shreg = wr_data;
          end else begin
            st_nxt.mdio_out = st_r.shreg[15];
            st_nxt.shreg = {st_r.shreg[14:0], 1'h0};
          end
          // Last bit: commit a write and release the pin
          if (st_r.cnt == `PLMC_DATA_BITS - 6'h01) begin
            wr_commit = st_r.hit && (hdr_op == `PLMC_OP_WRITE);
            st_nxt.fsm = PLMC_PRE;
            st_nxt.cnt = 6'h00;
            st_nxt.mdio_oe = 1'h0;
            st_nxt.mdio_out = 1'h0;
            st_nxt.hit = 1'h0;
          end
        end
        default: begin
          // Illegal state: back to hunting for a preamble
          st_nxt.fsm = PLMC_PRE;
          st_nxt.cnt = 6'h00;
          st_nxt.mdio_oe = 1'h0;
        end
      endcase
    end

    // ****************************************
    // Register writes
    // ****************************************
    // Only a hit frame commits; every write of one pulses the logic reset
    if (wr_commit && reg_lc) begin
      st_nxt.link_ctl = wr_data & LC_WMASK;
      st_nxt.logic_reset_pulse = wr_data[`PLMC_LC_LOGIC_RST];
    end
    if (wr_commit && reg_mc) begin
      st_nxt.mode_ctl = wr_data & MC_WMASK;
    end

    // ****************************************
    // Line energy status
    // ****************************************
    // Soft reset wins over the detector; soft reset clearing a set status requests the flag
    if (soft_rst) begin
      st_nxt.cfg.line_energy_present = 1'h0;
      st_nxt.energy_change_set = st_r.cfg.line_energy_present;
    end else begin
      st_nxt.cfg.line_energy_present = energy_detect;
    end

    // ****************************************
    // Configuration outputs
    // ****************************************
    // Fields lag their register by one cycle
    st_nxt.cfg.speed_opt_enable = st_r.mode_ctl[`PLMC_MC_SPD_EN];
    st_nxt.cfg.speed_opt_attempts =
      plmc_attempts(st_r.link_ctl[`PLMC_LC_SPD_HI:`PLMC_LC_SPD_LO]);
    st_nxt.cfg.link_break_enable = st_r.link_ctl[`PLMC_LC_LB_EN];
    st_nxt.cfg.link_break_thr_sel =
      st_r.link_ctl[`PLMC_LC_LBT_HI:`PLMC_LC_LBT_LO];
    st_nxt.cfg.link_break_thr_exp = `PLMC_THR_EXP_BASE
      + {2'h0, st_r.link_ctl[`PLMC_LC_LBT_HI:`PLMC_LC_LBT_LO]};
    st_nxt.cfg.power_opt_enable = ~st_r.link_ctl[`PLMC_LC_PWR_DIS];
    st_nxt.cfg.short_energy_detect_select =
      st_r.mode_ctl[`PLMC_MC_SHORT_ED];
    st_nxt.cfg.ten_meg_test_mode = st_r.mode_ctl[`PLMC_MC_FAST];
    st_nxt.cfg.energy_power_down_enable = st_r.mode_ctl[`PLMC_MC_EDPD];
    st_nxt.cfg.edpd_nlp_enable = st_r.mode_ctl[`PLMC_MC_NLP];
    st_nxt.cfg.next_page_enable = st_r.mode_ctl[`PLMC_MC_NP_EN];
    st_nxt.cfg.auto_mdix_enable = ~st_r.mode_ctl[`PLMC_MC_MDIX_DIS];
    // Manual selection per pair group when auto crossover is off
    if (st_r.mode_ctl[`PLMC_MC_MDIX_DIS]) begin
      st_nxt.cfg.mdix_pair_sel = mdix_manual_sel;
    end else begin
      st_nxt.cfg.mdix_pair_sel = mdix_auto_sel;
    end
    st_nxt.cfg.auto_np_disable = st_r.mode_ctl[`PLMC_MC_ANP_DIS];
    // With auto next page off the advertisement bit decides
    if (st_r.mode_ctl[`PLMC_MC_ANP_DIS]) begin
      st_nxt.cfg.np_advertise = adv_next_page;
    end else begin
      st_nxt.cfg.np_advertise = st_r.mode_ctl[`PLMC_MC_NP_EN];
    end
    st_nxt.cfg.semi_crossover_enable = st_r.mode_ctl[`PLMC_MC_SEMI];
  end

  // ****************************************
  // State register
  // ****************************************
  // Hardware reset restores register defaults and reports line energy
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign mdio_out = st_r.mdio_out;
  assign mdio_oe = st_r.mdio_oe;
  assign cfg = st_r.cfg;
  assign logic_reset_pulse = st_r.logic_reset_pulse;
  assign energy_change_set = st_r.energy_change_set;

endmodule
`default_nettype wire

/* testbench/phy_link_mode_control_regs_test.sv */
// Testbench of the link and mode control register pair
`include "plmc_cfg.svh"
`default_nettype none
module phy_link_mode_control_regs_test;
  import plmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, energy_detect = 1'b1;
  logic adv_next_page = 1'b1, mdc, mdio_in, mdio_out, mdio_oe, lrp, ecs;
  logic [1:0] man_sel = 2'h0, auto_sel = 2'h0;
  logic [4:0] phy_addr = 5'h05;
  plmc_cfg_t cfg;
  int mismatches = 0, samples_checked = 0, n_logic_reset_bit = 0, n_ec = 0, n_oe = 0, cycles = 0;
  localparam logic [4:0] LC = `PLMC_LINK_CTL_ADDR;
  localparam logic [4:0] MC = `PLMC_MODE_CTL_ADDR;
  always #12.5 mclk = ~mclk;
  plmc_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(phy_addr), .soft_rst(soft_rst),
    .energy_detect(energy_detect), .mdix_manual_sel(man_sel), .mdix_auto_sel(auto_sel),
    .adv_next_page(adv_next_page), .cfg(cfg), .logic_reset_pulse(lrp), .energy_change_set(ecs));
  plmc_sta_model u_sta (.mclk(mclk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe));
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    n_logic_reset_bit += (lrp === 1'b1);
    n_ec += (ecs === 1'b1);
    n_oe += (mdio_oe === 1'b1);
    if (cycles == 60000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    u_sta.xfer(phy_addr, ra, 1'b0, d, x);
  endtask
  task automatic rd(input logic [4:0] ra, output logic [15:0] d);
    u_sta.xfer(phy_addr, ra, 1'b1, 16'h0000, d);
  endtask
  function automatic logic [15:0] cfgv();
    return {4'h0, cfg.short_energy_detect_select, cfg.ten_meg_test_mode,
      cfg.energy_power_down_enable, cfg.edpd_nlp_enable, cfg.speed_opt_enable,
      cfg.next_page_enable, cfg.auto_mdix_enable, cfg.mdix_pair_sel,
      cfg.auto_np_disable, cfg.np_advertise, cfg.semi_crossover_enable};
  endfunction
  task automatic t_reset();
    logic [15:0] d;
    rd(LC, d);
    chk(d, 16'h0020);
    rd(MC, d);
    chk(d, 16'h0042);
    chk({13'h0, cfg.speed_opt_attempts}, 16'h0007);
    chk({15'h0, cfg.power_opt_enable}, 16'h0001);
  endtask
  task automatic t_link();
    logic [15:0] d, w;
    logic [2:0] tries [4];
    tries = '{3'h7, 3'h5, 3'h4, 3'h3};
    for (int i = 0; i < 4; i++) begin
      w = 16'hFCC2 | 16'(i << 8) | 16'(i << 4) | 16'((i & 1) << 3) | 16'((i >> 1) << 2);
      wr(LC, w);
      rd(LC, d);
      chk(d, w & 16'h033D);
      chk({13'h0, cfg.speed_opt_attempts}, {13'h0, tries[i]});
      chk({10'h0, cfg.link_break_thr_sel, cfg.link_break_thr_exp}, 16'(i * 17 + 8));
      chk({14'h0, cfg.link_break_enable, cfg.power_opt_enable}, 16'((i & 1) * 2 + 1 - (i >> 1)));
    end
  endtask
  task automatic t_logic_reset_bit();
    logic [15:0] d;
    int p;
    p = n_logic_reset_bit;
    wr(LC, 16'h0021);
    chk(16'(n_logic_reset_bit - p), 16'h0001);
    rd(LC, d);
    chk(d, 16'h0021);
    rd(LC, d);
    chk(d, 16'h0021);
    wr(LC, 16'h0021);
    wr(LC, 16'h0020);
    chk(16'(n_logic_reset_bit - p), 16'h0002);
  endtask
  task automatic t_mode();
    logic [15:0] d;
    man_sel = 2'h2;
    auto_sel = 2'h1;
    adv_next_page = 1'b0;
    wr(MC, 16'hFFFF);
    rd(MC, d);
    chk(d, 16'hF0F3);
    chk(cfgv(), 16'h0FD5);
    wr(MC, 16'h0000);
    rd(MC, d);
    chk(d, 16'h0002);
    chk(cfgv(), 16'h0028);
    adv_next_page = 1'b1;
    wr(MC, 16'h0010);
    chk(cfgv(), 16'h002E);
  endtask
  task automatic t_energy();
    logic [15:0] d;
    int p;
    energy_detect = 1'b0;
    rd(MC, d);
    chk(d & 16'h0002, 16'h0000);
    p = n_ec;
    soft_rst = 1'b1;
    @(negedge mclk);
    soft_rst = 1'b0;
    energy_detect = 1'b1;
    repeat (2) @(negedge mclk);
    chk(16'(n_ec - p), 16'h0000);
    soft_rst = 1'b1;
    repeat (3) @(negedge mclk);
    chk({15'h0, cfg.line_energy_present}, 16'h0000);
    soft_rst = 1'b0;
    @(negedge mclk);
    chk(16'(n_ec - p), 16'h0001);
    rd(MC, d);
    chk(d & 16'h0002, 16'h0002);
  endtask
  task automatic t_refuse();
    logic [15:0] d;
    int o;
    o = n_oe;
    u_sta.xfer(5'h06, LC, 1'b0, 16'h0335, d);
    u_sta.xfer(5'h06, LC, 1'b1, 16'h0000, d);
    chk(d, 16'hFFFF);
    chk(16'(n_oe - o), 16'h0000);
    rd(LC, d);
    chk(d, 16'h0020);
    wr(5'h12, 16'hFFFF);
    rd(5'h12, d);
    chk(d, 16'h0000);
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_link();
    t_logic_reset_bit();
    t_mode();
    t_energy();
    t_refuse();
    wrap_up();
  end
endmodule
`default_nettype wire

/* testbench/plmc_regs_assertions.sv */
// Checker of the link and mode control register pair
`default_nettype none
module plmc_regs_assertions (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                sys_rst,
  // Pins and core side
  input wire logic                mdio_oe,
  input wire logic                soft_rst,
  input wire logic                energy_detect,
  input wire logic [1:0]          mdix_manual_sel,
  input wire logic [1:0]          mdix_auto_sel,
  input wire logic                adv_next_page,
  input wire plmc_pkg::plmc_cfg_t cfg,
  input wire logic                logic_reset_pulse,
  input wire logic                energy_change_set
);
  import plmc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  tries_code_a: assert property (cfg.speed_opt_attempts inside {3'h7, 3'h5, 3'h4, 3'h3})
    else $error("attempt count off table");
  thr_exp_a: assert property (cfg.link_break_thr_exp == 4'h8 + cfg.link_break_thr_sel)
    else $error("threshold exponent wrong");
  manual_mdix_a: assert property (!cfg.auto_mdix_enable |-> cfg.mdix_pair_sel == $past(mdix_manual_sel))
    else $error("manual crossover not taken");
  auto_mdix_a: assert property (cfg.auto_mdix_enable && !$past(sys_rst) |-> cfg.mdix_pair_sel == $past(mdix_auto_sel))
    else $error("auto crossover not taken");
  np_adv_a: assert property (cfg.auto_np_disable && !$past(sys_rst) |-> cfg.np_advertise == $past(adv_next_page))
    else $error("next page not from advertisement");
  np_own_a: assert property (!cfg.auto_np_disable |-> cfg.np_advertise == cfg.next_page_enable)
    else $error("next page advertise wrong");
  energy_clear_a: assert property (soft_rst |=> !cfg.line_energy_present)
    else $error("energy not cleared");
  energy_flag_a: assert property (soft_rst && cfg.line_energy_present |=> energy_change_set)
    else $error("energy change not flagged");
  energy_cause_a: assert property (energy_change_set |-> $past(soft_rst) && $past(cfg.line_energy_present))
    else $error("spurious energy change");
  energy_follow_a: assert property (!$past(sys_rst) && !$past(soft_rst) |-> cfg.line_energy_present == $past(energy_detect))
    else $error("energy status stale");
  logic_reset_bit_pulse_a: assert property (logic_reset_pulse |-> !mdio_oe ##1 !logic_reset_pulse)
    else $error("logic reset pulse too long");
endmodule
bind plmc_regs plmc_regs_assertions u_chk (.mclk(mclk), .sys_rst(sys_rst), .mdio_oe(mdio_oe),
  .soft_rst(soft_rst), .energy_detect(energy_detect), .mdix_manual_sel(mdix_manual_sel),
  .mdix_auto_sel(mdix_auto_sel), .adv_next_page(adv_next_page), .cfg(cfg),
  .logic_reset_pulse(logic_reset_pulse), .energy_change_set(energy_change_set));
`default_nettype wire

/* testbench/plmc_sta_model.sv */
// Station management model issuing management frames
`default_nettype none
module plmc_sta_model (
  // Clock
  input  wire logic mclk,
  // Management pins
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_oe = 1'b0;
  logic host_val = 1'b1;
  initial mdc = 1'b0;
  // Pull-up when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (host_oe ? host_val : 1'b1);
  task automatic half(input logic lvl);
    repeat (8) @(negedge mclk);
    mdc = lvl;
  endtask
  task automatic bit_out(input logic b);
    host_oe = 1'b1;
    host_val = b;
    half(1'b1);
    half(1'b0);
  endtask
  task automatic xfer(input logic [4:0] pa, input logic [4:0] ra, input logic rd,
                      input logic [15:0] wd, output logic [15:0] rdat);
    logic [13:0] hdr;
    hdr = {2'b01, rd ? 2'b10 : 2'b01, pa, ra};
    rdat = 16'h0000;
    repeat (32) bit_out(1'b1);
    for (int i = 13; i >= 0; i--) bit_out(hdr[i]);
    if (rd) begin
      host_oe = 1'b0;
      for (int k = 0; k < 18; k++) begin
        half(1'b1);
        if (k >= 2) rdat = {rdat[14:0], mdio_in};
        half(1'b0);
      end
    end else begin
      bit_out(1'b1);
      bit_out(1'b0);
      for (int i = 15; i >= 0; i--) bit_out(wd[i]);
    end
    host_oe = 1'b0;
    half(1'b0);
  endtask
endmodule
`default_nettype wire
